// ### framer_clock_pkg.sv
// constants and types shared by the framer clock and pll control
package framer_clock_pkg;
    localparam int PORT_COUNT = 8;
    localparam int STRAP_W = 11;
    localparam int DIV_N_W = 6;
    localparam int DIV_M_W = 5;
    localparam int REG_W = 8;
    localparam int FREQ_W = 16;
    // strap bit positions, strap bit 0 is data pin 5
    localparam int STRAP_N_LSB = 0;
    localparam int STRAP_M_LSB = 6;
    // fixed mode internal dividers
    localparam logic [DIV_N_W-1:0] FIXED_N = 6'h21;
    localparam logic [DIV_M_W-1:0] FIXED_M = 5'h00;
    // host interface select codes for the serial interfaces
    localparam logic [1:0] HOST_IF_SPI = 2'h2;
    localparam logic [1:0] HOST_IF_SCI = 2'h3;
    localparam logic FLEX_RESET_VALUE = 1'b1;
    // receive clock rates in kHz, index is the rate select field
    localparam logic [FREQ_W-1:0] T1_KHZ_0 = 16'h0608;
    localparam logic [FREQ_W-1:0] T1_KHZ_1 = 16'h0C10;
    localparam logic [FREQ_W-1:0] T1_KHZ_2 = 16'h1820;
    localparam logic [FREQ_W-1:0] T1_KHZ_3 = 16'h3040;
    localparam logic [FREQ_W-1:0] E1_KHZ_0 = 16'h0800;
    localparam logic [FREQ_W-1:0] E1_KHZ_1 = 16'h1000;
    localparam logic [FREQ_W-1:0] E1_KHZ_2 = 16'h2000;
    localparam logic [FREQ_W-1:0] E1_KHZ_3 = 16'h4000;
    localparam logic [1:0] RATE_BASE = 2'h0;
    // reset pulse lengths
    localparam int CLK_PERIOD_NS = 10;
    localparam int PLL_RST_NS = 100;
    localparam int CLK_RST_NS = 50;
    localparam int PLL_RST_CYCLES = (PLL_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLK_RST_CYCLES = (CLK_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;

    typedef enum logic [2:0] {
        CORNER_2HZ = 3'b001,
        CORNER_0P2HZ = 3'b010,
        CORNER_ADJUST = 3'b100
    } corner_mode_t;

    typedef struct packed {
        corner_mode_t mode;
        logic [REG_W-1:0] cfg_three;
        logic [REG_W-1:0] cfg_four;
        logic [REG_W-1:0] cfg_five;
    } corner_cfg_t;

    typedef struct packed {
        logic [DIV_N_W-1:0] n;
        logic [DIV_M_W-1:0] m;
    } pll_div_t;

    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_PLL_RST = 3'b010,
        ST_CLK_RST = 3'b100
    } rst_state_t;
endpackage : framer_clock_pkg

// ### framer_clock_pll_control.sv
// central receive/transmit clock selection and pll reset control
`timescale 1ns/100ps
module framer_clock_pll_control #(
    parameter int PORTS = framer_clock_pkg::PORT_COUNT
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // line and host configuration
    input wire logic comp_mode_i,
    input wire logic [1:0] host_if_select_i,
    input wire logic chan_translate_i,
    input wire logic [PORTS-1:0] port_e1_mode_i,
    // receive clock rate
    input wire logic [1:0] clock_mode_reg_four_rs_i,
    input wire logic [1:0] clock_mode_reg_one_rs_i,
    input wire logic rx_clk_from_cdr_i,
    output logic [framer_clock_pkg::FREQ_W-1:0] rx_clock_khz_o,
    // oscillator corners
    input wire logic rx_corner_low_sel_i,
    input wire logic tx_corner_low_sel_i,
    input wire logic rx_corner_adjust_en_i,
    input wire logic tx_corner_adjust_en_i,
    input wire logic [framer_clock_pkg::REG_W-1:0] clock_mode_reg_three_i,
    input wire logic [framer_clock_pkg::REG_W-1:0] clock_mode_reg_four_i,
    input wire logic [framer_clock_pkg::REG_W-1:0] clock_mode_reg_five_i,
    output framer_clock_pkg::corner_cfg_t rx_digital_osc_o,
    output framer_clock_pkg::corner_cfg_t tx_digital_osc_o,
    // pll configuration writes
    input wire logic flex_wr_i,
    input wire logic flex_wdata_i,
    input wire logic div_a_wr_i,
    input wire logic div_b_wr_i,
    input wire logic [framer_clock_pkg::REG_W-1:0] div_wdata_i,
    input wire logic [framer_clock_pkg::STRAP_W-1:0] strap_i,
    output logic flex_freq_enable_o,
    output framer_clock_pkg::pll_div_t pll_div_o,
    output logic port_mode_mismatch_o,
    // resets toward the clock system
    output logic pll_reset_o,
    output logic clock_sys_reset_o,
    // lock input and status, then events with one entry per half
    input wire logic pll_lock_i,
    input wire logic [1:0] pll_lock_int_mask_i,
    input wire logic [1:0] pll_change_visible_i,
    input wire logic [1:0] pll_lock_clear_i,
    output logic pll_lock_status_o,
    output logic [1:0] pll_lock_changed_o,
    output logic [1:0] pll_lock_irq_o
);
    import framer_clock_pkg::*;

    localparam logic [CNT_W-1:0] PLL_CNT_LAST = CNT_W'(PLL_RST_CYCLES - 1);
    localparam logic [CNT_W-1:0] CLK_CNT_LAST = CNT_W'(CLK_RST_CYCLES - 1);

    logic serial_if;
    logic [1:0] rate_sel;
    logic line_e1;
    logic [FREQ_W-1:0] next_khz;
    logic flex_freq_enable;
    logic [DIV_N_W-1:0] pll_divider_reg_a;
    logic [DIV_M_W-1:0] pll_divider_reg_b;
    logic [STRAP_W-1:0] strap_q;
    logic strap_seen;
    logic [PORTS-1:0] port_mode_q;
    pll_div_t strap_div;
    pll_div_t reg_div;
    pll_div_t flex_div;
    logic div_a_change;
    logic div_b_change;
    logic strap_change;
    logic flex_toggle;
    logic pll_trigger;
    logic clk_trigger;
    rst_state_t state;
    logic [CNT_W-1:0] cnt;
    logic lock_q;
    logic lock_change;

    assign serial_if = (host_if_select_i == HOST_IF_SPI) || (host_if_select_i == HOST_IF_SCI);

    // receive clock rate; port one sets the line mode seen at this pin, channel translation forces E1
    assign rate_sel = comp_mode_i ? clock_mode_reg_one_rs_i : clock_mode_reg_four_rs_i;
    assign line_e1 = port_e1_mode_i[0] | chan_translate_i;

    always_comb begin
        next_khz = T1_KHZ_0;
        if (rx_clk_from_cdr_i) begin
            next_khz = line_e1 ? E1_KHZ_0 : T1_KHZ_0;
        end else begin
            case (rate_sel)
                2'h0: next_khz = line_e1 ? E1_KHZ_0 : T1_KHZ_0;
                2'h1: next_khz = line_e1 ? E1_KHZ_1 : T1_KHZ_1;
                2'h2: next_khz = line_e1 ? E1_KHZ_2 : T1_KHZ_2;
                default: next_khz = line_e1 ? E1_KHZ_3 : T1_KHZ_3;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_clock_khz_o <= T1_KHZ_0;
        end else begin
            rx_clock_khz_o <= next_khz;
        end
    end

    // oscillator corners
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_digital_osc_o <= '{mode: CORNER_2HZ, default: '0};
            tx_digital_osc_o <= '{mode: CORNER_2HZ, default: '0};
        end else begin
            rx_digital_osc_o.cfg_three <= clock_mode_reg_three_i;
            rx_digital_osc_o.cfg_four <= clock_mode_reg_four_i;
            rx_digital_osc_o.cfg_five <= clock_mode_reg_five_i;
            tx_digital_osc_o.cfg_three <= clock_mode_reg_three_i;
            tx_digital_osc_o.cfg_four <= clock_mode_reg_four_i;
            tx_digital_osc_o.cfg_five <= clock_mode_reg_five_i;
            if (rx_corner_adjust_en_i) begin
                rx_digital_osc_o.mode <= CORNER_ADJUST;
            end else begin
                rx_digital_osc_o.mode <= rx_corner_low_sel_i ? CORNER_0P2HZ : CORNER_2HZ;
            end
            if (tx_corner_adjust_en_i) begin
                tx_digital_osc_o.mode <= CORNER_ADJUST;
            end else begin
                tx_digital_osc_o.mode <= tx_corner_low_sel_i ? CORNER_0P2HZ : CORNER_2HZ;
            end
        end
    end

    // flexible enable, forced to flexible while reset is held
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flex_freq_enable <= FLEX_RESET_VALUE;
        end else if (flex_wr_i) begin
            flex_freq_enable <= flex_wdata_i;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pll_divider_reg_a <= FIXED_N;
            pll_divider_reg_b <= FIXED_M;
        end else begin
            if (div_a_wr_i) begin
                pll_divider_reg_a <= div_wdata_i[DIV_N_W-1:0];
            end
            if (div_b_wr_i) begin
                pll_divider_reg_b <= div_wdata_i[DIV_M_W-1:0];
            end
        end
    end

    // straps taken as the reference after the first clock past reset
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            strap_q <= '0;
            strap_seen <= 1'b0;
            port_mode_q <= '0;
        end else begin
            strap_q <= strap_i;
            strap_seen <= 1'b1;
            port_mode_q <= port_e1_mode_i;
        end
    end

    assign strap_div.n = strap_q[STRAP_N_LSB +: DIV_N_W];
    assign strap_div.m = strap_q[STRAP_M_LSB +: DIV_M_W];
    assign reg_div.n = pll_divider_reg_a;
    assign reg_div.m = pll_divider_reg_b;
    // serial host ignores register writes and uses the straps
    assign flex_div = serial_if ? strap_div : reg_div;

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pll_div_o <= '{n: FIXED_N, m: FIXED_M};
        end else if (flex_freq_enable) begin
            pll_div_o <= flex_div;
        end else begin
            pll_div_o <= '{n: FIXED_N, m: FIXED_M};
        end
    end

    assign flex_freq_enable_o = flex_freq_enable;

    // fixed mode has one pll setting, so ports must agree
    assign port_mode_mismatch_o = !flex_freq_enable && !((&port_e1_mode_i) || !(|port_e1_mode_i));

    // reset causes
    assign div_a_change = div_a_wr_i && (div_wdata_i[DIV_N_W-1:0] != pll_divider_reg_a);
    assign div_b_change = div_b_wr_i && (div_wdata_i[DIV_M_W-1:0] != pll_divider_reg_b);
    assign strap_change = strap_seen && (strap_i != strap_q);
    assign flex_toggle = flex_wr_i && (flex_wdata_i != flex_freq_enable);

    always_comb begin
        pll_trigger = 1'b0;
        if (flex_freq_enable) begin
            if (serial_if) begin
                pll_trigger = strap_change;
            end else begin
                pll_trigger = div_a_change || div_b_change;
            end
        end
        // fixed mode: divider writes and strap moves leave the pll alone
        if (flex_toggle && (flex_div != pll_div_t'{n: FIXED_N, m: FIXED_M})) begin
            pll_trigger = 1'b1;
        end
    end

    assign clk_trigger = (port_e1_mode_i != port_mode_q);

    // reset sequencer; a pll reset always runs into a clock system reset
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= ST_PLL_RST;
            cnt <= '0;
        end else begin
            case (state)
                ST_RUN: begin
                    if (pll_trigger) begin
                        state <= ST_PLL_RST;
                        cnt <= '0;
                    end else if (clk_trigger) begin
                        state <= ST_CLK_RST;
                        cnt <= '0;
                    end
                end
                ST_PLL_RST: begin
                    if (pll_trigger) begin
                        cnt <= '0;
                    end else if (cnt == PLL_CNT_LAST) begin
                        state <= ST_CLK_RST;
                        cnt <= '0;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                ST_CLK_RST: begin
                    if (pll_trigger) begin
                        state <= ST_PLL_RST;
                        cnt <= '0;
                    end else if (clk_trigger) begin
                        cnt <= '0;
                    end else if (cnt == CLK_CNT_LAST) begin
                        state <= ST_RUN;
                        cnt <= '0;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                default: begin
                    state <= ST_PLL_RST;
                    cnt <= '0;
                end
            endcase
        end
    end

    assign pll_reset_o = (state == ST_PLL_RST);
    assign clock_sys_reset_o = (state != ST_RUN);

    // lock change detection, status copied to both halves in comp mode, lower half only otherwise
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lock_q <= 1'b0;
        end else begin
            lock_q <= pll_lock_i;
        end
    end

    assign lock_change = (pll_lock_i != lock_q);
    assign pll_lock_status_o = lock_q;

    framer_lock_event half_lo (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .lock_change_i(lock_change),
        .mask_i(pll_lock_int_mask_i[0]),
        .visible_i(pll_change_visible_i[0]),
        .clear_i(pll_lock_clear_i[0]),
        .changed_o(pll_lock_changed_o[0]),
        .irq_o(pll_lock_irq_o[0])
    );

    framer_lock_event half_hi (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .lock_change_i(lock_change),
        .mask_i(pll_lock_int_mask_i[1] | !comp_mode_i),
        .visible_i(pll_change_visible_i[1] & comp_mode_i),
        .clear_i(pll_lock_clear_i[1]),
        .changed_o(pll_lock_changed_o[1]),
        .irq_o(pll_lock_irq_o[1])
    );

    property p_cdr_base;
        @(posedge clock_i) disable iff (!rst_b_i)
        rx_clk_from_cdr_i |=> (rx_clock_khz_o == E1_KHZ_0 || rx_clock_khz_o == T1_KHZ_0);
    endproperty
    a_cdr_base: assert property (p_cdr_base) else $error("recovered clock not at base rate");

    property p_adjust;
        @(posedge clock_i) disable iff (!rst_b_i)
        rx_corner_adjust_en_i |=> rx_digital_osc_o.mode == CORNER_ADJUST;
    endproperty
    a_adjust: assert property (p_adjust) else $error("adjust enable ignored");

    property p_fixed_div;
        @(posedge clock_i) disable iff (!rst_b_i)
        !flex_freq_enable |=> (pll_div_o == pll_div_t'{n: FIXED_N, m: FIXED_M});
    endproperty
    a_fixed_div: assert property (p_fixed_div) else $error("fixed dividers wrong");

    property p_div_reset;
        @(posedge clock_i) disable iff (!rst_b_i)
        (flex_freq_enable && !serial_if && div_a_change) |=> pll_reset_o;
    endproperty
    a_div_reset: assert property (p_div_reset) else $error("divider change did not reset pll");

    property p_fixed_quiet;
        @(posedge clock_i) disable iff (!rst_b_i)
        (state == ST_RUN && !flex_freq_enable && !flex_wr_i) |=> !pll_reset_o;
    endproperty
    a_fixed_quiet: assert property (p_fixed_quiet) else $error("pll reset in fixed mode");

    property p_strap_reset;
        @(posedge clock_i) disable iff (!rst_b_i)
        (flex_freq_enable && serial_if && strap_change) |=> pll_reset_o;
    endproperty
    a_strap_reset: assert property (p_strap_reset) else $error("strap change did not reset pll");

    property p_pll_then_clk;
        @(posedge clock_i) disable iff (!rst_b_i)
        $fell(pll_reset_o) |-> clock_sys_reset_o;
    endproperty
    a_pll_then_clk: assert property (p_pll_then_clk) else $error("clock system not reset after pll");

    property p_mode_change;
        @(posedge clock_i) disable iff (!rst_b_i)
        (state == ST_RUN && clk_trigger && !pll_trigger) |=> (clock_sys_reset_o && !pll_reset_o);
    endproperty
    a_mode_change: assert property (p_mode_change) else $error("mode change reset wrong");

    property p_reset_flex;
        @(posedge clock_i)
        $rose(rst_b_i) |-> (flex_freq_enable && pll_reset_o);
    endproperty
    a_reset_flex: assert property (p_reset_flex) else $error("reset state wrong");
endmodule : framer_clock_pll_control

// ### framer_lock_event.sv
// pll lock change flag, mask and visibility for one register half
`timescale 1ns/100ps
module framer_lock_event (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // event and software control
    input wire logic lock_change_i,
    input wire logic mask_i,
    input wire logic visible_i,
    input wire logic clear_i,
    // status
    output logic changed_o,
    output logic irq_o
);
    import framer_clock_pkg::*;

    logic changed;

    // set beats clear so a change in the clear cycle survives
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            changed <= 1'b0;
        end else if (lock_change_i) begin
            changed <= 1'b1;
        end else if (clear_i) begin
            changed <= 1'b0;
        end
    end

    assign changed_o = changed & visible_i;
    assign irq_o = changed & ~mask_i;

    property p_set_wins;
        @(posedge clock_i) disable iff (!rst_b_i)
        lock_change_i |=> changed;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("lock change lost");

    property p_irq_gate;
        @(posedge clock_i) disable iff (!rst_b_i)
        (lock_change_i && !mask_i) |=> (irq_o || mask_i);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("unmasked change raised no interrupt");
endmodule : framer_lock_event

// ### ref_strap_model.sv
// far side model: strap pins and pll lock seen from the reference clock
`timescale 1ns/100ps
module ref_strap_model #(
    parameter int LOCK_DELAY = 4
) (
    // clock and pll reset
    input wire logic clock_i,
    input wire logic pll_reset_i,
    // strap request from the bench
    input wire logic [framer_clock_pkg::STRAP_W-1:0] strap_req_i,
    // pins toward the device
    output logic [framer_clock_pkg::STRAP_W-1:0] strap_o,
    output logic pll_lock_o
);
    import framer_clock_pkg::*;
    logic [STRAP_W-1:0] strap_q = '0;
    logic lock_q = 1'b0;
    int lock_cnt = 0;
    assign strap_o = strap_q;
    assign pll_lock_o = lock_q;
    // straps move off the sampling edge only
    always @(negedge clock_i) begin
        strap_q <= strap_req_i;
    end
    // lock lost on every pll reset, regained after a settling time
    always @(posedge clock_i) begin
        if (pll_reset_i) begin
            lock_cnt <= 0;
            lock_q <= 1'b0;
        end else if (lock_cnt < LOCK_DELAY) begin
            lock_cnt <= lock_cnt + 1;
        end else begin
            lock_q <= 1'b1;
        end
    end
endmodule : ref_strap_model

// ### tb_top.sv
// self-checking bench for the framer clock and pll control
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin mismatches++; \
    $display("BAD %s exp %0h got %0h", nm, ex, gt); end end
module tb_top;
    import framer_clock_pkg::*;
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic comp_mode_i = 1'b1;
    logic [1:0] host_if_select_i = 2'h0;
    logic chan_translate_i = 1'b0;
    logic [7:0] port_e1_mode_i = 8'h00;
    logic [1:0] rs_four = 2'h0;
    logic [1:0] rs_one = 2'h0;
    logic cdr = 1'b0;
    logic [3:0] corner_in = 4'h0;
    logic [2:0] wr_sel = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic [10:0] strap_req = 11'h000;
    logic [1:0] mask = 2'h2;
    logic [1:0] vis = 2'h3;
    logic [1:0] clr = 2'h0;
    logic [10:0] strap;
    logic [15:0] khz;
    logic [15:0] base;
    logic lock, flex_o, mism, pll_rst, clk_rst, lock_st;
    logic [1:0] chg, irq;
    corner_cfg_t rx_osc, tx_osc;
    pll_div_t div_o;
    int cp, cc;
    int mismatches = 0;
    int total_checks = 0;
    // clock runs from time zero, so master clock is up before release
    always #5 clock_i = ~clock_i;
    framer_clock_pll_control #(.PORTS(8)) dut_u (.clock_i(clock_i), .rst_b_i(rst_b_i),
        .comp_mode_i(comp_mode_i), .host_if_select_i(host_if_select_i), .chan_translate_i(chan_translate_i),
        .port_e1_mode_i(port_e1_mode_i), .clock_mode_reg_four_rs_i(rs_four), .clock_mode_reg_one_rs_i(rs_one),
        .rx_clk_from_cdr_i(cdr), .rx_clock_khz_o(khz), .rx_corner_low_sel_i(corner_in[2]),
        .tx_corner_low_sel_i(corner_in[0]), .rx_corner_adjust_en_i(corner_in[3]),
        .tx_corner_adjust_en_i(corner_in[1]), .clock_mode_reg_three_i(8'hA3), .clock_mode_reg_four_i(8'h4B),
        .clock_mode_reg_five_i(8'h5C), .rx_digital_osc_o(rx_osc), .tx_digital_osc_o(tx_osc),
        .flex_wr_i(wr_sel[2]), .flex_wdata_i(wdata[0]), .div_a_wr_i(wr_sel[0]), .div_b_wr_i(wr_sel[1]),
        .div_wdata_i(wdata), .strap_i(strap), .flex_freq_enable_o(flex_o), .pll_div_o(div_o),
        .port_mode_mismatch_o(mism), .pll_reset_o(pll_rst), .clock_sys_reset_o(clk_rst), .pll_lock_i(lock),
        .pll_lock_int_mask_i(mask), .pll_change_visible_i(vis), .pll_lock_clear_i(clr),
        .pll_lock_status_o(lock_st), .pll_lock_changed_o(chg), .pll_lock_irq_o(irq));
    ref_strap_model #(.LOCK_DELAY(4)) model_u (.clock_i(clock_i), .pll_reset_i(pll_rst),
        .strap_req_i(strap_req), .strap_o(strap), .pll_lock_o(lock));
    // long enough for one pll reset plus clock reset
    task automatic watch();
        cp = 0;
        cc = 0;
        // sample before waiting, so a reset raised by the last edge is counted
        repeat (30) begin
            if (pll_rst === 1'b1) cp++;
            if (clk_rst === 1'b1) cc++;
            @(negedge clock_i);
        end
    endtask : watch
    // one-cycle write strobe: bit2 flexible enable, bit1 divider b, bit0 divider a
    task automatic op(input logic [2:0] sel, input logic [7:0] v);
        @(negedge clock_i);
        wr_sel = sel;
        wdata = v;
        @(negedge clock_i);
        wr_sel = 3'h0;
        watch();
    endtask : op
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (5) @(negedge clock_i);
        `CHK("flex at reset", 1'b1, flex_o)
        `CHK("pll rst in reset", 1'b1, pll_rst)
        `CHK("div at reset", {FIXED_N, FIXED_M}, div_o)
        `CHK("rx corner at reset", CORNER_2HZ, rx_osc.mode)
        `CHK("tx corner at reset", CORNER_2HZ, tx_osc.mode)
        rst_b_i = 1'b1;
        watch();
        `CHK("clk rst outlasts pll", 1'b1, cc > cp && cp > 0)
        `CHK("lock status", 1'b1, lock_st)
        `CHK("lock changed", 2'h3, chg)
        `CHK("lock irq masked", 2'h1, irq)
        clr = 2'h1;
        @(negedge clock_i);
        clr = 2'h0;
        vis = 2'h1;
        @(negedge clock_i);
        `CHK("half0 cleared half1 hidden", 2'h0, chg)
        vis = 2'h3;
        @(negedge clock_i);
        `CHK("half1 still set", 2'h2, chg)
        $display("test reset and lock done");
        for (int t = 0; t < 4; t++) begin
            port_e1_mode_i = {8{t[0]}};
            chan_translate_i = t[1];
            watch();
            `CHK("mode change clk rst", t != 0, cc != 0)
            `CHK("mode change pll kept", 0, cp)
            base = (t != 0) ? 16'h0800 : 16'h0608;
            for (int i = 0; i < 16; i++) begin
                comp_mode_i = i[3];
                cdr = i[2];
                rs_four = i[3] ? ~i[1:0] : i[1:0];
                rs_one = i[3] ? i[1:0] : ~i[1:0];
                repeat (2) @(negedge clock_i);
                `CHK("rx rate", cdr ? base : base << i[1:0], khz)
            end
        end
        comp_mode_i = 1'b1;
        port_e1_mode_i = 8'h00;
        for (int i = 0; i < 16; i++) begin
            corner_in = i[3:0];
            repeat (2) @(negedge clock_i);
            `CHK("rx corner", i[3] ? CORNER_ADJUST : i[2] ? CORNER_0P2HZ : CORNER_2HZ, rx_osc.mode)
            `CHK("tx corner", i[1] ? CORNER_ADJUST : i[0] ? CORNER_0P2HZ : CORNER_2HZ, tx_osc.mode)
            if (i[3]) `CHK("rx cfg", 24'hA34B5C, {rx_osc.cfg_three, rx_osc.cfg_four, rx_osc.cfg_five})
            if (i[1]) `CHK("tx cfg", 24'hA34B5C, {tx_osc.cfg_three, tx_osc.cfg_four, tx_osc.cfg_five})
        end
        $display("test rates and corners done");
        op(3'h1, 8'h20);
        `CHK("div write pll rst", 10, cp)
        `CHK("clock system follows", 15, cc)
        `CHK("div n", 6'h20, div_o.n)
        op(3'h1, 8'h20);
        `CHK("same div no rst", 0, cp)
        op(3'h4, 8'h00);
        `CHK("flex off differs", 1'b1, cp != 0)
        `CHK("flex off", 1'b0, flex_o)
        `CHK("fixed div", {FIXED_N, FIXED_M}, div_o)
        op(3'h2, 8'h05);
        `CHK("fixed write no rst", 0, cp)
        port_e1_mode_i = 8'h01;
        watch();
        `CHK("mixed ports flagged", 1'b1, mism)
        `CHK("mixed ports pll kept", 0, cp)
        port_e1_mode_i = 8'h00;
        op(3'h4, 8'h01);
        `CHK("flex on differs", 1'b1, cp != 0)
        op(3'h1, 8'h21);
        op(3'h2, 8'h00);
        op(3'h4, 8'h00);
        `CHK("flex off equal", 0, cp)
        $display("test parallel host done");
        for (int h = 2; h < 4; h++) begin
            host_if_select_i = h[1:0];
            strap_req = 11'h2AA;
            watch();
            `CHK("fixed strap ignored", 0, cp)
            op(3'h4, 8'h01);
            `CHK("flex on strap differs", 1'b1, cp != 0)
            `CHK("div from strap", {6'h2A, 5'h0A}, div_o)
            strap_req = 11'h021;
            watch();
            `CHK("strap change rst", 1'b1, cp != 0)
            op(3'h1, 8'h11);
            `CHK("serial reg write no rst", 0, cp)
            op(3'h4, 8'h00);
            `CHK("fixed strap equal", 0, cp)
        end
        $display("test serial host done");
        close_out();
    end
    // whole run is near 900 cycles
    initial begin
        repeat (6000) @(posedge clock_i);
        mismatches++;
        close_out();
    end
endmodule : tb_top
